/* File: hdl/scrb_map.svh */
// register map offsets, field positions and reset values of the serial config bank
`ifndef SCRB_MAP_SVH
`define SCRB_MAP_SVH
`define SCRB_WORD_W 32
`define SCRB_ADDR_MSB 3
`define SCRB_ADDR_OUT_LAST 4'h7
`define SCRB_ADDR_PDF 4'hB
`define SCRB_ADDR_GLOBAL 4'hE
`define SCRB_ADDR_LOOP 4'hF
`define SCRB_RESET_BIT 31
`define SCRB_DLY_MSB 7
`define SCRB_DLY_LSB 4
`define SCRB_DIV_MSB 15
`define SCRB_DIV_LSB 8
`define SCRB_EN_BIT 16
`define SCRB_MUX_MSB 18
`define SCRB_MUX_LSB 17
`define SCRB_PDF_BIT 15
`define SCRB_GEN_BIT 27
`define SCRB_PD_BIT 26
`define SCRB_TRI_BIT 25
`define SCRB_POL_BIT 24
`define SCRB_LDMUX_MSB 23
`define SCRB_LDMUX_LSB 20
`define SCRB_RDIV_MSB 19
`define SCRB_RDIV_LSB 8
`define SCRB_GAIN_MSB 31
`define SCRB_GAIN_LSB 30
`define SCRB_NDIV_MSB 25
`define SCRB_NDIV_LSB 8
`define SCRB_DLY_DEF 4'h0
`define SCRB_DIV_DEF 8'h01
`define SCRB_EN_DEF 1'b0
`define SCRB_MUX_DEF 2'h0
`define SCRB_PDF_DEF 1'b0
`define SCRB_GEN_DEF 1'b1
`define SCRB_PD_DEF 1'b0
`define SCRB_TRI_DEF 1'b0
`define SCRB_POL_DEF 1'b0
`define SCRB_LDMUX_DEF 4'h0
`define SCRB_RDIV_DEF 12'h00A
`define SCRB_GAIN_DEF 2'h0
`define SCRB_NDIV_DEF 18'h002F8
`endif

/* File: hdl/scrb_pkg.sv */
// types and default values of the serial config bank
package scrb_pkg;
  `include "scrb_map.svh"

  typedef struct packed {
    logic [1:0] path_select;
    logic enable;
    logic [7:0] divide;
    logic [3:0] delay;
  } scrb_out_cfg_s;

  typedef struct packed {
    logic global_enable;
    logic power_down;
    logic cp_high_z;
    logic cp_polarity;
    logic [3:0] lock_mux;
    logic [11:0] ref_divide;
  } scrb_global_s;

  typedef struct packed {
    logic [1:0] cp_gain;
    logic [17:0] fb_divide;
  } scrb_loop_s;

  typedef scrb_out_cfg_s [7:0] scrb_out_arr_t;
  typedef logic [7:0][8:0] scrb_ratio_arr_t;

  localparam scrb_out_cfg_s SCRB_OUT_DEF = '{`SCRB_MUX_DEF, `SCRB_EN_DEF, `SCRB_DIV_DEF, `SCRB_DLY_DEF};
  localparam scrb_global_s SCRB_GLOBAL_DEF = '{`SCRB_GEN_DEF, `SCRB_PD_DEF, `SCRB_TRI_DEF, `SCRB_POL_DEF,
                                               `SCRB_LDMUX_DEF, `SCRB_RDIV_DEF};
  localparam scrb_loop_s SCRB_LOOP_DEF = '{`SCRB_GAIN_DEF, `SCRB_NDIV_DEF};
endpackage : scrb_pkg

/* File: hdl/scrb_sync.sv */
// two-flop synchroniser for the serial link pins
`timescale 1ns/10ps
module scrb_sync #(
  parameter int WIDTH = 3
) (
  input wire logic i_clock, // system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic [WIDTH-1:0] i_async, // raw pin levels
  output logic [WIDTH-1:0] o_sync // levels after two flops
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // first stage feeds only the second, to let metastability settle
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      stage1 <= '0;
      stage2 <= '0;
    end
    else
    begin
      stage1 <= i_async;
      stage2 <= stage1;
    end
  end

  assign o_sync = stage2;
endmodule : scrb_sync

/* File: hdl/scrb_bank.sv */
// serial three-wire configuration register bank of the clock conditioner
`timescale 1ns/10ps
`include "scrb_map.svh"
module scrb_bank
  import scrb_pkg::*;
(
  input wire logic i_clock, // 10 MHz system clock
  input wire logic i_rstn, // async reset, active low
  input wire logic i_serial_shift_clock, // serial clock pin
  input wire logic i_serial_data_in, // serial data pin
  input wire logic i_serial_latch_enable, // latch enable pin
  output scrb_out_arr_t o_out_cfg, // per-output settings
  output scrb_ratio_arr_t o_div_ratio, // effective divide ratio per output
  output logic [7:0] o_div_invalid, // divide code zero per output
  output logic o_pdf_range_select, // phase detector range bit
  output scrb_global_s o_global_cfg, // global and reference settings
  output scrb_loop_s o_loop_cfg, // loop gain and feedback divider
  output logic o_cfg_update, // pulse: a word was latched
  output logic o_soft_reset // pulse: soft reset word latched
);
  logic [2:0] pins_s;
  logic sclk_s;
  logic sdi_s;
  logic le_s;
  logic sclk_q;
  logic le_q;
  logic sclk_rise;
  logic le_rise;
  logic [`SCRB_WORD_W-1:0] shift;
  scrb_out_arr_t out_cfg;
  scrb_ratio_arr_t ratio;
  logic [7:0] invalid;
  logic pdf;
  scrb_global_s glob;
  scrb_loop_s loop;
  logic upd;
  logic srst;
  logic [`SCRB_WORD_W-1:0] next_shift;
  scrb_out_arr_t next_out_cfg;
  scrb_ratio_arr_t next_ratio;
  logic [7:0] next_invalid;
  logic next_pdf;
  scrb_global_s next_glob;
  scrb_loop_s next_loop;
  logic next_upd;
  logic next_srst;

  // unpack one output register from a received word
  function automatic scrb_out_cfg_s scrb_word_to_out(input logic [`SCRB_WORD_W-1:0] w);
    scrb_out_cfg_s c;
    c.path_select = w[`SCRB_MUX_MSB:`SCRB_MUX_LSB];
    c.enable = w[`SCRB_EN_BIT];
    c.divide = w[`SCRB_DIV_MSB:`SCRB_DIV_LSB];
    c.delay = w[`SCRB_DLY_MSB:`SCRB_DLY_LSB];
    return c;
  endfunction : scrb_word_to_out

  // address field of a word
  function automatic logic [3:0] scrb_addr(input logic [`SCRB_WORD_W-1:0] w);
    return w[`SCRB_ADDR_MSB:0];
  endfunction : scrb_addr

  // pins come from the host's domain, so they pass two flops first
  scrb_sync #(
    .WIDTH(3)
  ) u_sync (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_async({i_serial_shift_clock, i_serial_data_in, i_serial_latch_enable}),
    .o_sync(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign sdi_s = pins_s[1];
  assign le_s = pins_s[0];
  // edges seen on synchronised levels; serial clock must stay below fclk/4
  assign sclk_rise = sclk_s & ~sclk_q;
  assign le_rise = le_s & ~le_q;

  // next values of shifter and register bank
  always_comb
  begin
    next_shift = shift;
    next_out_cfg = out_cfg;
    next_pdf = pdf;
    next_glob = glob;
    next_loop = loop;
    next_upd = 1'b0;
    next_srst = 1'b0;
    if (sclk_rise && !le_s)
    begin
      next_shift = {shift[`SCRB_WORD_W-2:0], sdi_s};
    end
    if (le_rise)
    begin
      next_upd = 1'b1;
      if (scrb_addr(shift) <= `SCRB_ADDR_OUT_LAST)
      begin
        if (scrb_addr(shift) == 4'h0 && shift[`SCRB_RESET_BIT])
        begin
          // rest of the word is dropped; reset bit is never stored
          next_srst = 1'b1;
          next_out_cfg = {8{SCRB_OUT_DEF}};
          next_pdf = `SCRB_PDF_DEF;
          next_glob = SCRB_GLOBAL_DEF;
          next_loop = SCRB_LOOP_DEF;
        end
        else
        begin
          // address top bit is zero here, so the low three bits pick the output
          next_out_cfg[shift[2:0]] = scrb_word_to_out(shift);
        end
      end
      else
      begin
        case (scrb_addr(shift))
          `SCRB_ADDR_PDF: next_pdf = shift[`SCRB_PDF_BIT];
          `SCRB_ADDR_GLOBAL:
          begin
            next_glob.global_enable = shift[`SCRB_GEN_BIT];
            next_glob.power_down = shift[`SCRB_PD_BIT];
            next_glob.cp_high_z = shift[`SCRB_TRI_BIT];
            next_glob.cp_polarity = shift[`SCRB_POL_BIT];
            next_glob.lock_mux = shift[`SCRB_LDMUX_MSB:`SCRB_LDMUX_LSB];
            next_glob.ref_divide = shift[`SCRB_RDIV_MSB:`SCRB_RDIV_LSB];
          end
          `SCRB_ADDR_LOOP:
          begin
            next_loop.cp_gain = shift[`SCRB_GAIN_MSB:`SCRB_GAIN_LSB];
            next_loop.fb_divide = shift[`SCRB_NDIV_MSB:`SCRB_NDIV_LSB];
          end
          default: next_pdf = pdf; // unused addresses change no register but still pulse o_cfg_update
        endcase
      end
    end
    // ratio follows the stored code so it is never a cycle stale
    for (int i = 0; i < 8; i++)
    begin
      next_ratio[i] = {next_out_cfg[i].divide, 1'b0};
      next_invalid[i] = (next_out_cfg[i].divide == 8'h00);
    end
  end

  // register everything; defaults equal the power-on content
  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      sclk_q <= 1'b0;
      le_q <= 1'b0;
      shift <= '0;
      out_cfg <= {8{SCRB_OUT_DEF}};
      ratio <= {8{9'h002}};
      invalid <= 8'h00;
      pdf <= `SCRB_PDF_DEF;
      glob <= SCRB_GLOBAL_DEF;
      loop <= SCRB_LOOP_DEF;
      upd <= 1'b0;
      srst <= 1'b0;
    end
    else
    begin
      sclk_q <= sclk_s;
      le_q <= le_s;
      shift <= next_shift;
      out_cfg <= next_out_cfg;
      ratio <= next_ratio;
      invalid <= next_invalid;
      pdf <= next_pdf;
      glob <= next_glob;
      loop <= next_loop;
      upd <= next_upd;
      srst <= next_srst;
    end
  end

  // outputs are the bank flops themselves
  assign o_out_cfg = out_cfg;
  assign o_div_ratio = ratio;
  assign o_div_invalid = invalid;
  assign o_pdf_range_select = pdf;
  assign o_global_cfg = glob;
  assign o_loop_cfg = loop;
  assign o_cfg_update = upd;
  assign o_soft_reset = srst;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);

  AST_SHIFT_MSB_FIRST: assert property (
    sclk_rise && !le_s |=> shift == {$past(shift[`SCRB_WORD_W-2:0]), $past(sdi_s)})
    else $error("shift did not take the data bit");
  AST_HOLD_WHILE_LATCHED: assert property (
    le_s |=> $stable(shift))
    else $error("shift moved while latch enable high");
  AST_OUT_LATCH: assert property (
    le_rise && shift[3:0] == 4'h5 |=> out_cfg[5].divide == $past(shift[15:8]) && o_cfg_update)
    else $error("output five not written from word");
  AST_OUT_FIELDS: assert property (
    le_rise && shift[3:0] == 4'h2 |=> out_cfg[2] == {$past(shift[18:17]), $past(shift[16]),
      $past(shift[15:8]), $past(shift[7:4])})
    else $error("output field layout wrong");
  AST_SOFT_RESET: assert property (
    le_rise && shift[3:0] == 4'h0 && shift[31] |=> out_cfg[0].divide == 8'h01 && !out_cfg[0].enable
      && loop.fb_divide == 18'h002F8 && glob.ref_divide == 12'h00A && o_soft_reset)
    else $error("soft reset did not restore defaults");
  AST_PDF_WRITE: assert property (
    le_rise && shift[3:0] == 4'hB |=> pdf == $past(shift[15]))
    else $error("range bit not written");
  AST_GLOBAL_WRITE: assert property (
    le_rise && shift[3:0] == 4'hE |=> glob.ref_divide == $past(shift[19:8])
      && glob.global_enable == $past(shift[27]))
    else $error("global register not written");
  AST_LOOP_WRITE: assert property (
    le_rise && shift[3:0] == 4'hF |=> loop == {$past(shift[31:30]), $past(shift[25:8])})
    else $error("loop register not written");
  AST_UNMAPPED: assert property (
    le_rise && shift[3:0] == 4'h9 |=> $stable(out_cfg) && $stable(glob) && $stable(loop))
    else $error("unused address changed state");
  AST_RATIO: assert property (
    1'b1 |-> o_div_ratio[7] == {out_cfg[7].divide, 1'b0} && o_div_invalid[7] == (out_cfg[7].divide == 8'h00))
    else $error("divide ratio wrong");
endmodule : scrb_bank

/* File: sim/scrb_host_model.sv */
// host model that shifts configuration words into the bank over the three-wire link
`timescale 1ns/10ps
module scrb_host_model (
  input wire logic i_clock, // system clock, paces the link
  output logic o_serial_shift_clock, // serial clock pin
  output logic o_serial_data_in, // serial data pin
  output logic o_serial_latch_enable // latch enable pin
);
  // idle link sits low, serial clock stands still between frames
  initial
  begin
    o_serial_shift_clock = 1'b0;
    o_serial_data_in = 1'b0;
    o_serial_latch_enable = 1'b0;
  end

  // one word: 32 bits msb first, clock high three cycles and low four so the sync chain sees it
  task automatic write_word(input logic [31:0] w);
    for (int i = 31; i >= 0; i--)
    begin
      @(posedge i_clock);
      #1 o_serial_data_in = w[i];
      repeat (3) @(posedge i_clock);
      #1 o_serial_shift_clock = 1'b1;
      repeat (3) @(posedge i_clock);
      #1 o_serial_shift_clock = 1'b0;
    end
    repeat (2) @(posedge i_clock);
    // data back low with the latch rise, held well past the last clock rise
    #1 o_serial_data_in = 1'b0;
    o_serial_latch_enable = 1'b1;
    repeat (6) @(posedge i_clock);
    #1 o_serial_latch_enable = 1'b0;
    repeat (2) @(posedge i_clock);
  endtask : write_word
endmodule : scrb_host_model

/* File: sim/scrb_bank_test.sv */
// self-checking bench of the serial config register bank
`timescale 1ns/10ps
module scrb_bank_test
  import scrb_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_rstn = 1'b0;
  wire logic sclk, sdata, le;
  scrb_out_arr_t out_cfg, e_out;
  scrb_ratio_arr_t ratio;
  logic [7:0] inval;
  logic pdf, upd, srst, e_pdf;
  scrb_global_s glb, e_glb;
  scrb_loop_s lp, e_lp;
  int e_upd = 0, e_srst = 0, n_upd = 0, n_srst = 0, failures = 0, n_compared = 0, cycles = 0;
  logic [15:0] seed = 16'h88CF;
  logic [31:0] r;

  always #50 i_clock = ~i_clock;

  scrb_host_model u_host (.i_clock(i_clock), .o_serial_shift_clock(sclk), .o_serial_data_in(sdata),
    .o_serial_latch_enable(le));

  scrb_bank u_dut (.i_clock(i_clock), .i_rstn(i_rstn), .i_serial_shift_clock(sclk), .i_serial_data_in(sdata),
    .i_serial_latch_enable(le), .o_out_cfg(out_cfg), .o_div_ratio(ratio), .o_div_invalid(inval),
    .o_pdf_range_select(pdf), .o_global_cfg(glb), .o_loop_cfg(lp), .o_cfg_update(upd), .o_soft_reset(srst));

  // pulse counters and the hang limit; a word takes about 235 cycles
  always @(posedge i_clock)
  begin
    n_upd += (upd === 1'b1);
    n_srst += (srst === 1'b1);
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      summarize();
    end
  end

  // two single-bit lfsr steps fill the two halves, which share 15 bits
  function automatic logic [31:0] get_rnd();
    logic [31:0] v;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    v[15:0] = seed;
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    v[31:16] = seed;
    return v;
  endfunction : get_rnd

  // host writes only the documented fields of mapped addresses, fixed bits zero; unused addresses get random bits 27:4
  function automatic logic [31:0] mask(input logic [3:0] a);
    if (a <= 4'h7) return 32'h0007FFF0;
    case (a)
      4'hB: return 32'h00008000;
      4'hE: return 32'h0FFFFF00;
      4'hF: return 32'hC3FFFF00;
      default: return 32'h0FFFFFF0;
    endcase
  endfunction : mask

  task automatic check_cfg(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check_cfg

  task automatic check_cnt(input string what, input int exp, input int got);
    n_compared++;
    if (got != exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check_cnt

  task automatic set_defaults();
    e_out = {8{SCRB_OUT_DEF}};
    e_pdf = 1'b0;
    e_glb = SCRB_GLOBAL_DEF;
    e_lp = SCRB_LOOP_DEF;
  endtask : set_defaults

  task automatic compare_all();
    for (int i = 0; i < 8; i++)
    begin
      check_cfg("out_cfg", e_out[i], out_cfg[i]);
      check_cfg("div_ratio", {e_out[i].divide, 1'b0}, ratio[i]);
      check_cfg("div_invalid", e_out[i].divide == 8'h00, inval[i]);
    end
    check_cfg("pdf_range", e_pdf, pdf);
    check_cfg("global_cfg", e_glb, glb);
    check_cfg("loop_cfg", e_lp, lp);
    check_cnt("updates", e_upd, n_upd);
    check_cnt("soft_resets", e_srst, n_srst);
  endtask : compare_all

  // send a word, predict its effect, then compare every output
  task automatic send(input logic [31:0] w);
    u_host.write_word(w);
    e_upd++;
    if (w[3:0] == 4'h0 && w[31])
    begin
      set_defaults();
      e_srst++;
    end
    else if (!w[3])
      e_out[w[2:0]] = {w[18:17], w[16], w[15:8], w[7:4]};
    else if (w[3:0] == 4'hB)
      e_pdf = w[15];
    else if (w[3:0] == 4'hE)
      e_glb = w[27:8];
    else if (w[3:0] == 4'hF)
      e_lp = {w[31:30], w[25:8]};
    compare_all();
  endtask : send

  task automatic summarize();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    repeat (10) @(posedge i_clock);
    #1 i_rstn = 1'b1;
    repeat (3) @(posedge i_clock);
    set_defaults();
    compare_all();
    r = get_rnd();
    send({1'b1, r[30:4], 4'h0});
    // ascending passes over all sixteen addresses, unmapped ones must change nothing
    for (int p = 0; p < 2; p++)
      for (int a = 0; a < 16; a++)
      begin
        r = get_rnd();
        send((r & mask(4'(a))) | 32'(a));
      end
    send(32'h00070035);
    send(32'h0000FFF7);
    r = get_rnd();
    send({1'b1, r[30:4], 4'h0});
    summarize();
  end
endmodule : scrb_bank_test
